/* File: hw/offcore_response_event_filter.sv */
`timescale 1ns/1ps
// Contract
// RQ1 - Software programs the filter configuration for each off-core event used.
// RQ2 - Bits 15:0 hold the request-type selection mask.
// RQ3 - Bits 29:16 hold the supplier-information selection mask.
// RQ4 - Bits 37:30 hold the snoop-response selection mask.
// RQ5 - Bit 0 selects demand data and page-table reads, not prefetches.
// RQ6 - Bit 1 selects demand ownership reads, not L2 ownership prefetches.
// RQ7 - Bit 2 selects demand instruction reads and L1 instruction prefetches; here REQ_PREFETCH never matches, whatever bit 2 holds.
// RQ8 - Bits 14:3 reserved; bit 15 selects I/O, uncacheable, other requests.
// RQ9 - Bit 16 accepts any response type.
// RQ10 - Bit 17 selects responses with no supplier information.
// RQ11 - Bits 18-20 select third-level hits in M, E, S; bit 21 reserved.
// RQ12 - Bit 22 selects fourth-level cache hits; bits 23-25 reserved.
// RQ13 - Bit 26 selects local DRAM supply; bits 27-29 reserved.
// RQ14 - Bit 30 selects fourth-level super-line hits, shared by both fields.
// RQ15 - Bit 31 selects responses with no snoop detail.
// RQ16 - Bit 32 selects requests needing no snoop.
// RQ17 - Bit 33 selects snoops that missed every snooped cache.
// RQ18 - Bit 34 selects snoop hits without data forwarding.
// RQ19 - Bit 35 selects snoops forwarding clean data, line left shared.
// RQ20 - Bit 36 selects snoops finding the line modified.
// RQ21 - Bit 37 selects transactions to non-DRAM addresses.
// RQ22 - Count only when request and response both match set bits.
// RQ23 - Reserved bits ignored; register clears to zero on reset.
module offcore_response_event_filter #(
   parameter int CFG_WIDTH = ocr_filter_pkg::CFG_W
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Configuration register access.
   input wire logic cfg_wr_i,
   input wire logic [CFG_WIDTH-1:0] cfg_wdata_i,
   output logic [CFG_WIDTH-1:0] cfg_rdata_o,
   // Completed transaction.
   input wire logic txn_valid_i,
   input wire ocr_filter_pkg::txn_s txn_i,
   // Count pulse to the counter.
   output logic count_o
);

   logic [CFG_WIDTH-1:0] cfg;
   logic [CFG_WIDTH-1:0] next_cfg;
   logic count;
   logic next_count;
   logic req_hit;
   logic rsp_hit;

   // Only implemented bits are stored, so reserved ones can never match.
   always_comb begin
      next_cfg = cfg;
      if (cfg_wr_i) begin
         next_cfg = cfg_wdata_i
            & CFG_WIDTH'(ocr_filter_pkg::CFG_IMPL_MASK); // RQ23
      end
   end

   // Request type decode.
   function automatic logic req_match(
      input logic [CFG_WIDTH-1:0] c,
      input ocr_filter_pkg::request_kind_e k
   );
      logic r;
      r = 1'b0;
      case (k)
         ocr_filter_pkg::REQ_DEMAND_DATA: begin
            r = c[ocr_filter_pkg::DEMAND_DATA_READ_BIT]; // RQ5
         end
         ocr_filter_pkg::REQ_DEMAND_OWNERSHIP: begin
            r = c[ocr_filter_pkg::DEMAND_OWNERSHIP_READ_BIT]; // RQ6
         end
         ocr_filter_pkg::REQ_DEMAND_INSTRUCTION: begin
            r = c[ocr_filter_pkg::DEMAND_INSTRUCTION_READ_BIT]; // RQ7
         end
         ocr_filter_pkg::REQ_OTHER: begin
            r = c[ocr_filter_pkg::OTHER_REQUEST_BIT]; // RQ8
         end
         // Prefetches have no selector on this core.
         default: begin
            r = 1'b0; // RQ5
         end
      endcase
      return r;
   endfunction : req_match

   // Response decode: any-bit, supplier field, snoop field.
   function automatic logic rsp_match(
      input logic [CFG_WIDTH-1:0] c,
      input ocr_filter_pkg::txn_s t
   );
      logic s;
      logic p;
      s = 1'b0;
      p = 1'b0;
      case (t.supplier)
         ocr_filter_pkg::SUP_UNKNOWN: begin
            s = c[ocr_filter_pkg::SUPPLIER_UNKNOWN_BIT]; // RQ10
         end
         ocr_filter_pkg::SUP_L3_MODIFIED: begin
            s = c[ocr_filter_pkg::THIRD_LEVEL_HIT_MODIFIED_BIT]; // RQ11
         end
         ocr_filter_pkg::SUP_L3_EXCLUSIVE: begin
            s = c[ocr_filter_pkg::THIRD_LEVEL_HIT_EXCLUSIVE_BIT]; // RQ11
         end
         ocr_filter_pkg::SUP_L3_SHARED: begin
            s = c[ocr_filter_pkg::THIRD_LEVEL_HIT_SHARED_BIT]; // RQ11
         end
         ocr_filter_pkg::SUP_L4: begin
            s = c[ocr_filter_pkg::FOURTH_LEVEL_HIT_BIT]; // RQ12
         end
         ocr_filter_pkg::SUP_LOCAL_DRAM: begin
            s = c[ocr_filter_pkg::LOCAL_DRAM_BIT]; // RQ13
         end
         ocr_filter_pkg::SUP_SUPER_LINE: begin
            s = c[ocr_filter_pkg::SUPER_LINE_HIT_BIT]; // RQ14
         end
         default: begin
            s = 1'b0;
         end
      endcase
      case (t.probe)
         ocr_filter_pkg::SNP_NONE: begin
            p = c[ocr_filter_pkg::PROBE_NONE_BIT]; // RQ15
         end
         ocr_filter_pkg::SNP_NOT_NEEDED: begin
            p = c[ocr_filter_pkg::PROBE_NOT_NEEDED_BIT]; // RQ16
         end
         ocr_filter_pkg::SNP_MISS: begin
            p = c[ocr_filter_pkg::PROBE_MISS_BIT]; // RQ17
         end
         ocr_filter_pkg::SNP_HIT_UNFORWARDED: begin
            p = c[ocr_filter_pkg::PROBE_HIT_UNFORWARDED_BIT]; // RQ18
         end
         ocr_filter_pkg::SNP_HIT_FORWARDED: begin
            p = c[ocr_filter_pkg::PROBE_HIT_FORWARDED_BIT]; // RQ19
         end
         ocr_filter_pkg::SNP_HIT_MODIFIED: begin
            p = c[ocr_filter_pkg::PROBE_HIT_MODIFIED_BIT]; // RQ20
         end
         default: begin
            p = 1'b0;
         end
      endcase
      if (t.non_dram) begin
         p = p | c[ocr_filter_pkg::NON_DRAM_TARGET_BIT]; // RQ21
      end
      return c[ocr_filter_pkg::ANY_RESPONSE_BIT] | s | p; // RQ9
   endfunction : rsp_match

   always_comb begin
      req_hit = req_match(cfg, txn_i.request);
      rsp_hit = rsp_match(cfg, txn_i);
      next_count = txn_valid_i & req_hit & rsp_hit; // RQ22
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg <= CFG_WIDTH'(ocr_filter_pkg::CFG_RESET); // RQ23
         count <= 1'b0;
      end else begin
         cfg <= next_cfg; // RQ2 RQ3 RQ4
         count <= next_count;
      end
   end

   assign cfg_rdata_o = cfg;
   assign count_o = count;

   // Qualified requests, so each response check below can reach the count.
   logic data_txn;
   logic other_txn;
   assign data_txn = txn_valid_i
      && txn_i.request == ocr_filter_pkg::REQ_DEMAND_DATA
      && cfg[ocr_filter_pkg::DEMAND_DATA_READ_BIT];
   assign other_txn = txn_valid_i
      && txn_i.request == ocr_filter_pkg::REQ_OTHER
      && cfg[ocr_filter_pkg::OTHER_REQUEST_BIT];

   AST_OWN_COUNTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      txn_valid_i && txn_i.request == ocr_filter_pkg::REQ_DEMAND_OWNERSHIP
      && cfg[ocr_filter_pkg::DEMAND_OWNERSHIP_READ_BIT]
      && cfg[ocr_filter_pkg::ANY_RESPONSE_BIT] |=> count_o) // RQ6
      else $error("ownership read missed");

   AST_INSTR_COUNTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      txn_valid_i && txn_i.request == ocr_filter_pkg::REQ_DEMAND_INSTRUCTION
      && cfg[ocr_filter_pkg::DEMAND_INSTRUCTION_READ_BIT]
      && cfg[ocr_filter_pkg::ANY_RESPONSE_BIT] |=> count_o) // RQ7
      else $error("instruction read missed");

   AST_SUP_UNKNOWN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_txn && txn_i.supplier == ocr_filter_pkg::SUP_UNKNOWN
      && cfg[ocr_filter_pkg::SUPPLIER_UNKNOWN_BIT] |=> count_o) // RQ10
      else $error("unknown supplier missed");

   AST_SUP_L3_M: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_txn && txn_i.supplier == ocr_filter_pkg::SUP_L3_MODIFIED
      && cfg[ocr_filter_pkg::THIRD_LEVEL_HIT_MODIFIED_BIT] |=> count_o) // RQ11
      else $error("modified hit missed");

   AST_SUP_L3_E: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_txn && txn_i.supplier == ocr_filter_pkg::SUP_L3_EXCLUSIVE
      && cfg[ocr_filter_pkg::THIRD_LEVEL_HIT_EXCLUSIVE_BIT] |=> count_o) // RQ11
      else $error("exclusive hit missed");

   AST_SUP_L3_S: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_txn && txn_i.supplier == ocr_filter_pkg::SUP_L3_SHARED
      && cfg[ocr_filter_pkg::THIRD_LEVEL_HIT_SHARED_BIT] |=> count_o) // RQ11
      else $error("shared hit missed");

   AST_SUP_L4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_txn && txn_i.supplier == ocr_filter_pkg::SUP_L4
      && cfg[ocr_filter_pkg::FOURTH_LEVEL_HIT_BIT] |=> count_o) // RQ12
      else $error("fourth-level hit missed");

   AST_SUP_DRAM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_txn && txn_i.supplier == ocr_filter_pkg::SUP_LOCAL_DRAM
      && cfg[ocr_filter_pkg::LOCAL_DRAM_BIT] |=> count_o) // RQ13
      else $error("local memory supply missed");

   AST_SUP_SPLIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_txn && txn_i.supplier == ocr_filter_pkg::SUP_SUPER_LINE
      && cfg[ocr_filter_pkg::SUPER_LINE_HIT_BIT] |=> count_o) // RQ14
      else $error("super-line hit missed");

   AST_PRB_NONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      other_txn && txn_i.probe == ocr_filter_pkg::SNP_NONE
      && cfg[ocr_filter_pkg::PROBE_NONE_BIT] |=> count_o) // RQ15
      else $error("no-detail snoop missed");

   AST_PRB_NOT_NEEDED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      other_txn && txn_i.probe == ocr_filter_pkg::SNP_NOT_NEEDED
      && cfg[ocr_filter_pkg::PROBE_NOT_NEEDED_BIT] |=> count_o) // RQ16
      else $error("unneeded snoop missed");

   AST_PRB_MISS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      other_txn && txn_i.probe == ocr_filter_pkg::SNP_MISS
      && cfg[ocr_filter_pkg::PROBE_MISS_BIT] |=> count_o) // RQ17
      else $error("snoop miss missed");

   AST_PRB_HIT_NF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      other_txn && txn_i.probe == ocr_filter_pkg::SNP_HIT_UNFORWARDED
      && cfg[ocr_filter_pkg::PROBE_HIT_UNFORWARDED_BIT] |=> count_o) // RQ18
      else $error("unforwarded snoop hit missed");

   AST_PRB_HIT_F: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      other_txn && txn_i.probe == ocr_filter_pkg::SNP_HIT_FORWARDED
      && cfg[ocr_filter_pkg::PROBE_HIT_FORWARDED_BIT] |=> count_o) // RQ19
      else $error("forwarded snoop hit missed");

   AST_PRB_HIT_M: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      other_txn && txn_i.probe == ocr_filter_pkg::SNP_HIT_MODIFIED
      && cfg[ocr_filter_pkg::PROBE_HIT_MODIFIED_BIT] |=> count_o) // RQ20
      else $error("modified snoop hit missed");

   AST_NON_DRAM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      other_txn && txn_i.non_dram
      && cfg[ocr_filter_pkg::NON_DRAM_TARGET_BIT] |=> count_o) // RQ21
      else $error("non-memory target missed");

   // A write and a transaction in one cycle match against the old value.
   AST_COUNT_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      count_o |-> $past(txn_valid_i)) // RQ22
      else $error("count without transaction");

   AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cfg_rdata_o & ~ocr_filter_pkg::CFG_IMPL_MASK) == '0) // RQ23
      else $error("reserved config bit set");

   AST_ANY_COUNTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      txn_valid_i && cfg[ocr_filter_pkg::ANY_RESPONSE_BIT]
      && req_match(cfg, txn_i.request) |=> count_o) // RQ9
      else $error("any-response match missed");

   AST_NO_REQ_NO_COUNT: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      txn_valid_i && cfg[15:0] == 16'h0000 |=> !count_o) // RQ2
      else $error("count with empty request mask");

   AST_PREFETCH_NEVER: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      txn_i.request == ocr_filter_pkg::REQ_PREFETCH |=> !count_o) // RQ5
      else $error("prefetch counted");

   AST_NO_RSP_NO_COUNT: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      txn_valid_i && cfg[37:16] == 22'h00_0000 |=> !count_o) // RQ3
      else $error("count with empty response masks");

   AST_WRITE_TAKES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cfg_wr_i |=> cfg_rdata_o ==
      ($past(cfg_wdata_i) & ocr_filter_pkg::CFG_IMPL_MASK)) // RQ4
      else $error("config write lost");

   AST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !cfg_wr_i |=> $stable(cfg_rdata_o)) // RQ23
      else $error("config changed without write");

   COV_COUNT: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      count_o);
   COV_BACK_TO_BACK: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      count_o ##1 count_o);
   COV_WRITE_THEN_COUNT: cover property (@(posedge clk_i)
      disable iff (!rst_n_i) cfg_wr_i ##1 count_o);

endmodule : offcore_response_event_filter

/* File: hw/ocr_filter_pkg.sv */
package ocr_filter_pkg;

   localparam int CFG_W = 64;
   localparam logic [63:0] CFG_RESET = 64'h0000_0000_0000_0000;

   localparam int REQ_LSB = 0;
   localparam int REQ_MSB = 15;
   localparam int SUP_LSB = 16;
   localparam int SUP_MSB = 29;
   localparam int SNP_LSB = 30;
   localparam int SNP_MSB = 37;

   localparam int DEMAND_DATA_READ_BIT = 0;
   localparam int DEMAND_OWNERSHIP_READ_BIT = 1;
   localparam int DEMAND_INSTRUCTION_READ_BIT = 2;
   localparam int OTHER_REQUEST_BIT = 15;

   localparam int ANY_RESPONSE_BIT = 16;
   localparam int SUPPLIER_UNKNOWN_BIT = 17;
   localparam int THIRD_LEVEL_HIT_MODIFIED_BIT = 18;
   localparam int THIRD_LEVEL_HIT_EXCLUSIVE_BIT = 19;
   localparam int THIRD_LEVEL_HIT_SHARED_BIT = 20;
   localparam int FOURTH_LEVEL_HIT_BIT = 22;
   localparam int LOCAL_DRAM_BIT = 26;
   localparam int SUPER_LINE_HIT_BIT = 30;
   localparam int PROBE_NONE_BIT = 31;
   localparam int PROBE_NOT_NEEDED_BIT = 32;
   localparam int PROBE_MISS_BIT = 33;
   localparam int PROBE_HIT_UNFORWARDED_BIT = 34;
   localparam int PROBE_HIT_FORWARDED_BIT = 35;
   localparam int PROBE_HIT_MODIFIED_BIT = 36;
   localparam int NON_DRAM_TARGET_BIT = 37;

   // Bits that take part in matching; everything else is reserved.
   localparam logic [63:0] CFG_IMPL_MASK = 64'h0000_003F_C45F_8007;

   typedef enum logic [2:0] {
      REQ_DEMAND_DATA,
      REQ_DEMAND_OWNERSHIP,
      REQ_DEMAND_INSTRUCTION,
      REQ_PREFETCH,
      REQ_OTHER
   } request_kind_e;

   typedef enum logic [2:0] {
      SUP_UNKNOWN,
      SUP_L3_MODIFIED,
      SUP_L3_EXCLUSIVE,
      SUP_L3_SHARED,
      SUP_L4,
      SUP_LOCAL_DRAM,
      SUP_SUPER_LINE,
      SUP_OTHER
   } supplier_kind_e;

   typedef enum logic [2:0] {
      SNP_NONE,
      SNP_NOT_NEEDED,
      SNP_MISS,
      SNP_HIT_UNFORWARDED,
      SNP_HIT_FORWARDED,
      SNP_HIT_MODIFIED,
      SNP_UNREPORTED
   } probe_kind_e;

   typedef struct packed {
      request_kind_e request;
      supplier_kind_e supplier;
      probe_kind_e probe;
      logic non_dram;
   } txn_s;

endpackage : ocr_filter_pkg

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   logic [63:0] cfg_wdata_i = '0;
   logic [63:0] cfg_rdata_o;
   logic txn_valid_i = 1'b0;
   ocr_filter_pkg::txn_s txn_i = '0;
   logic count_o;
   int fails = 0;
   int compares = 0;
   // Select bits per kind, in enum order; prefetch points at a reserved bit.
   int rb[5] = '{0, 1, 2, 3, 15};
   int sb[7] = '{17, 18, 19, 20, 22, 26, 30};
   int pb[6] = '{31, 32, 33, 34, 35, 36};

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   offcore_response_event_filter u_dut (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .cfg_wr_i(cfg_wr_i),
      .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o),
      .txn_valid_i(txn_valid_i),
      .txn_i(txn_i),
      .count_o(count_o)
   );

   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         fails++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk

   // Writes the mask, then offers one transaction and judges the pulse.
   task automatic run(input logic [63:0] c, input ocr_filter_pkg::txn_s t,
                      input logic e);
      @(negedge clk_i);
      cfg_wr_i = 1'b1;
      cfg_wdata_i = c;
      @(negedge clk_i);
      cfg_wr_i = 1'b0;
      chk(cfg_rdata_o === (c & ocr_filter_pkg::CFG_IMPL_MASK), "readback");
      txn_valid_i = 1'b1;
      txn_i = t;
      @(negedge clk_i);
      txn_valid_i = 1'b0;
      chk(count_o === e, "count pulse");
      @(negedge clk_i);
      chk(count_o === 1'b0, "pulse longer than one cycle");
   endtask : run

   task automatic test_reset;
      chk(cfg_rdata_o === '0, "config not clear after reset");
      chk(count_o === 1'b0, "count high after reset");
      run('1, '0, 1'b1);
      @(negedge clk_i);
      rst_n_i = 1'b0;
      @(negedge clk_i);
      chk(cfg_rdata_o === '0, "config not clear in reset");
      rst_n_i = 1'b1;
      $display("test_reset done");
   endtask : test_reset

   task automatic test_request;
      ocr_filter_pkg::txn_s t;
      logic [63:0] own;
      for (int i = 0; i < 5; i++) begin
         t = '0;
         t.request = ocr_filter_pkg::request_kind_e'(i);
         t.supplier = ocr_filter_pkg::SUP_OTHER;
         t.probe = ocr_filter_pkg::SNP_UNREPORTED;
         own = 64'h1 << rb[i];
         run(own | (64'h1 << 16), t, i != 3);
         run((~own & 64'hffff) | (64'h1 << 16), t, 1'b0);
      end
      t.request = ocr_filter_pkg::REQ_DEMAND_DATA;
      run(64'h1, t, 1'b0);
      $display("test_request done");
   endtask : test_request

   task automatic test_supplier;
      ocr_filter_pkg::txn_s t;
      for (int i = 0; i < 7; i++) begin
         t = '0;
         t.request = ocr_filter_pkg::REQ_DEMAND_DATA;
         t.supplier = ocr_filter_pkg::supplier_kind_e'(i);
         t.probe = ocr_filter_pkg::SNP_UNREPORTED;
         run(64'h1 | (64'h1 << sb[i]), t, 1'b1);
         run(64'h1 | (64'h1 << sb[(i + 1) % 7]), t, 1'b0);
      end
      $display("test_supplier done");
   endtask : test_supplier

   task automatic test_probe;
      ocr_filter_pkg::txn_s t;
      for (int i = 0; i < 6; i++) begin
         t = '0;
         t.request = ocr_filter_pkg::REQ_OTHER;
         t.supplier = ocr_filter_pkg::SUP_OTHER;
         t.probe = ocr_filter_pkg::probe_kind_e'(i);
         run((64'h1 << 15) | (64'h1 << pb[i]), t, 1'b1);
         run((64'h1 << 15) | (64'h1 << pb[(i + 1) % 6]), t, 1'b0);
      end
      t.probe = ocr_filter_pkg::SNP_UNREPORTED;
      t.non_dram = 1'b1;
      run((64'h1 << 15) | (64'h1 << 37), t, 1'b1);
      t.non_dram = 1'b0;
      run((64'h1 << 15) | (64'h1 << 37), t, 1'b0);
      $display("test_probe done");
   endtask : test_probe

   task automatic summarize;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   // The whole sequence needs about 170 cycles; 10000 cycles, some sixty times that, is a hang.
   initial begin
      #40000;
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      summarize();
   end

   initial begin
      repeat (6) @(negedge clk_i);
      rst_n_i = 1'b1;
      test_reset();
      test_request();
      test_supplier();
      test_probe();
      summarize();
   end
endmodule : testbench
